//--- rtl/background_debug_registers.sv
// Contract
// - set shift-data-valid when read data sent or write data received
// - clear shift-data-valid on next command received or on debug exit
// - set single-step-active when single-step command is first recognized
// - single-step-active stays set until resume or resume-until; here a status write with ST_STEP low also clears it
// - when secured, release bit writable only in special mode by secure firmware
// - release bit zero on secure entry; secure firmware table then mapped (here only in special mode)
// - erase verified sets release, maps standard table; failure keeps it clear
// - release set means security off; next reset secures again
// - release bit meaningless when flash security byte is unsecured
// - saved flags reset to D8 in special mode, zero otherwise
// - debug entry copies the CPU condition codes into saved flags
// - debug write to saved flags changes the restored condition codes
// - saved flags and page registers accessible only via debug, unsecured
// - page access enable turns paged debug access on or off
// - debug register commands never perform global accesses
// - four-bit page index selects the page for paged debug accesses
// - eight-bit read-only family identifier readable in active debug
// - debug enable gates activation; hardware commands still accepted
// - debug-active set on entry, cleared by firmware store on exit
`timescale 1ns/10ps
`default_nettype none
module background_debug_registers #(
  parameter logic [7:0] FAMILY_IDENTIFIER = debug_regs_pkg::FAMILY_IDENTIFIER_DEFAULT
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_special_mode,
  input  wire logic                      i_flash_secured,
  input  wire debug_regs_pkg::reg_req_t  i_req,
  input  wire logic                      i_global_req,
  input  wire logic                      i_reg_cmd,
  input  wire logic                      i_cmd_received,
  input  wire logic                      i_data_done,
  input  wire logic                      i_step_cmd,
  input  wire logic                      i_resume_cmd,
  input  wire logic                      i_enter_req,
  input  wire logic                      i_exit_store,
  input  wire logic                      i_erase_done,
  input  wire logic                      i_erase_ok,
  input  wire logic [7:0]                i_cpu_ccr,
  output logic [7:0]                     o_rdata,
  output logic                           o_rvalid,
  output logic                           o_debug_active,
  output logic                           o_debug_enable,
  output logic                           o_secure,
  output logic                           o_secure_table,
  output logic [7:0]                     o_restore_ccr,
  output var debug_regs_pkg::page_sel_t  o_page
);

  logic       enable,   next_enable;
  logic       active,   next_active;
  logic       shift_data_valid,      next_sdv;
  logic       step,     next_step;
  logic       release_b, next_release;
  logic [7:0] flags,    next_flags;
  logic [7:0] page,     next_page;
  logic [7:0] rdata,    next_rdata;
  logic       rvalid,   next_rvalid;
  logic       secure_latched, next_secure_latched;
  logic       started,  next_started;
  logic       secured;
  logic       access_ok;
  logic [1:0] mode_sync;
  logic [1:0] secured_sync;
  logic       special_mode;
  logic       flash_secured;

  function automatic logic hit(input logic [17:0] a, input logic [17:0] b);
    return a == b;
  endfunction

  // security follows the flash byte unless released
  assign secured   = secure_latched & ~release_b;
  assign access_ok = ~secured;

  // strap pins pass two flops before the capture logic reads them
  always_ff @(posedge i_core_clk) begin
    mode_sync    <= {mode_sync[0], i_special_mode};
    secured_sync <= {secured_sync[0], i_flash_secured};
  end
  assign special_mode  = mode_sync[1];
  assign flash_secured = secured_sync[1];

  always_comb begin
    next_started        = 1'b1;
    next_secure_latched = secure_latched;
    next_enable  = enable;
    next_active  = active;
    next_sdv     = shift_data_valid;
    next_step    = step;
    next_release = release_b;
    next_flags   = flags;
    next_page    = page;
    next_rdata   = rdata;
    next_rvalid  = 1'b0;
    if (!started) begin
      // capture mode straps after release of reset
      next_secure_latched = flash_secured;
      next_release = 1'b0;
      next_active  = special_mode;
      next_enable  = special_mode & ~flash_secured;
      next_flags   = special_mode ? debug_regs_pkg::FLAGS_RST_SPECIAL
                                    : debug_regs_pkg::FLAGS_RST_OTHER;
    end else begin
      if (i_cmd_received) begin
        next_sdv = 1'b0;
      end
      if (i_data_done) begin
        next_sdv = 1'b1;
      end
      if (i_step_cmd) begin
        next_step = 1'b1;
      end else if (i_resume_cmd) begin
        next_step = 1'b0;
      end
      if (i_enter_req && enable && !active) begin
        next_active = 1'b1;
        next_flags  = i_cpu_ccr;
      end
      if (i_exit_store && active) begin
        next_active = 1'b0;
        next_sdv    = 1'b0;
      end
      if (i_erase_done && secure_latched && special_mode) begin
        next_enable  = 1'b1;
        next_release = i_erase_ok;
      end
      if (i_req.wr && access_ok) begin
        if (hit(i_req.addr, debug_regs_pkg::ADDR_FLAGS)) begin
          next_flags = i_req.wdata;
        end
        if (hit(i_req.addr, debug_regs_pkg::ADDR_PAGE)) begin
          next_page = i_req.wdata & 8'h8F;
        end
        if (hit(i_req.addr, debug_regs_pkg::ADDR_STATUS)) begin
          next_enable = i_req.wdata[debug_regs_pkg::ST_ENABLE];
          next_step   = i_req.wdata[debug_regs_pkg::ST_STEP];
        end
      end
      if (i_req.wr && hit(i_req.addr, debug_regs_pkg::ADDR_STATUS)
          && (!secure_latched || (special_mode && i_req.fw_src))) begin
        next_release = i_req.wdata[debug_regs_pkg::ST_RELEASE];
      end
      if (i_req.rd) begin
        next_rvalid = 1'b1;
        next_rdata  = debug_regs_pkg::ZERO_BYTE;
        if (hit(i_req.addr, debug_regs_pkg::ADDR_STATUS) && access_ok) begin
          next_rdata = {enable, active, 1'b0, shift_data_valid, step, 1'b0, release_b, 1'b0};
        end
        if (hit(i_req.addr, debug_regs_pkg::ADDR_FLAGS) && access_ok) begin
          next_rdata = flags;
        end
        if (hit(i_req.addr, debug_regs_pkg::ADDR_PAGE) && access_ok) begin
          next_rdata = page;
        end
        if (hit(i_req.addr, debug_regs_pkg::ADDR_FAMILY) && active) begin
          next_rdata = FAMILY_IDENTIFIER;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      started        <= 1'b0;
      secure_latched <= 1'b1;
      enable         <= 1'b0;
      active         <= 1'b0;
      shift_data_valid            <= 1'b0;
      step           <= 1'b0;
      release_b      <= 1'b0;
      flags          <= debug_regs_pkg::FLAGS_RST_OTHER;
      page           <= debug_regs_pkg::PAGE_RST;
      rdata          <= debug_regs_pkg::ZERO_BYTE;
      rvalid         <= 1'b0;
    end else begin
      started        <= next_started;
      secure_latched <= next_secure_latched;
      enable         <= next_enable;
      active         <= next_active;
      shift_data_valid            <= next_sdv;
      step           <= next_step;
      release_b      <= next_release;
      flags          <= next_flags;
      page           <= next_page;
      rdata          <= next_rdata;
      rvalid         <= next_rvalid;
    end
  end

  assign o_rdata        = rdata;
  assign o_rvalid       = rvalid;
  assign o_debug_active = active;
  assign o_debug_enable = enable;
  assign o_secure       = secured;
  assign o_secure_table = secure_latched & ~release_b & special_mode;
  assign o_restore_ccr  = flags;
  assign o_page = '{
    page_en:   page[debug_regs_pkg::PG_ENABLE],
    page_idx:  page[debug_regs_pkg::PG_IDX_HI:0],
    global_en: i_global_req & ~i_reg_cmd
  };

  a_sdv_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_data_done |=> shift_data_valid)
    else $error("sdv not set");

  a_sdv_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_cmd_received && !i_data_done |=> !shift_data_valid)
    else $error("sdv not cleared");

  a_sdv_exit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_exit_store && active |=> !shift_data_valid)
    else $error("sdv kept after exit");

  a_step_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_step_cmd |=> step)
    else $error("step not set");

  a_step_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && step && !i_resume_cmd && !(i_req.wr && access_ok) |=> step)
    else $error("step dropped");

  a_step_resume: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_resume_cmd && !i_step_cmd && !i_req.wr |=> !step)
    else $error("step kept after resume");

  a_release_guard: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && secure_latched && !special_mode && !release_b |=> !release_b)
    else $error("release set outside special mode");

  a_release_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !started |=> !release_b)
    else $error("release not clear after reset");

  a_table_secure: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && secure_latched && !release_b && special_mode |-> o_secure_table)
    else $error("secure table not mapped");

  a_erase_pass: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_erase_done && i_erase_ok && secure_latched && special_mode
      && !i_req.wr |=> release_b)
    else $error("release not set on erased flash");

  a_erase_fail: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_erase_done && !i_erase_ok && secure_latched && special_mode
      && !i_req.wr |=> !release_b)
    else $error("release set on failed erase");

  a_release_open: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && release_b |-> !o_secure)
    else $error("secured while released");

  a_flash_open: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && !secure_latched |-> !o_secure && !o_secure_table)
    else $error("secured with open flash byte");

  a_flags_reset: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !started && special_mode |=> flags == debug_regs_pkg::FLAGS_RST_SPECIAL)
    else $error("flags reset wrong");

  a_flags_entry: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_enter_req && enable && !active && !i_req.wr |=> flags == $past(i_cpu_ccr))
    else $error("flags not saved");

  a_flags_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_req.wr && access_ok && hit(i_req.addr, debug_regs_pkg::ADDR_FLAGS)
      |=> o_restore_ccr == $past(i_req.wdata))
    else $error("restore flags not written");

  a_secure_refuse: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && secured && i_req.rd && hit(i_req.addr, debug_regs_pkg::ADDR_FLAGS)
      |=> o_rdata == debug_regs_pkg::ZERO_BYTE)
    else $error("flags readable while secured");

  a_secure_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && secured && !i_enter_req |=> $stable(flags))
    else $error("flags written while secured");

  a_read_answer: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_req.rd |=> o_rvalid)
    else $error("read not answered");

  a_read_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_req.rd |=> !o_rvalid)
    else $error("read answer without request");

  a_page_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_req.wr && access_ok && hit(i_req.addr, debug_regs_pkg::ADDR_PAGE)
      |=> o_page.page_en == $past(i_req.wdata[debug_regs_pkg::PG_ENABLE])
      && o_page.page_idx == $past(i_req.wdata[debug_regs_pkg::PG_IDX_HI:0]))
    else $error("page select not written");

  a_global_block: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_reg_cmd |-> !o_page.global_en)
    else $error("global access on register command");

  a_family_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_req.rd && active && hit(i_req.addr, debug_regs_pkg::ADDR_FAMILY)
      |=> o_rdata == FAMILY_IDENTIFIER)
    else $error("family code not returned");

  a_no_activate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && !enable && !active |=> !active)
    else $error("activated while disabled");

  a_enable_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !started |=> enable == ($past(special_mode) && !$past(flash_secured)))
    else $error("enable capture wrong");

  a_active_entry: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_enter_req && enable && !active |=> active)
    else $error("debug entry missed");

  a_active_exit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    started && i_exit_store && active |=> !active)
    else $error("debug exit missed");

endmodule // background_debug_registers
`default_nettype wire

//--- rtl/debug_regs_pkg.sv
package debug_regs_pkg;

  localparam int unsigned ADDR_W = 18;

  // register addresses in the debug map
  localparam logic [17:0] ADDR_STATUS = 18'h3FF01;
  localparam logic [17:0] ADDR_FLAGS  = 18'h3FF06;
  localparam logic [17:0] ADDR_PAGE   = 18'h3FF08;
  localparam logic [17:0] ADDR_FAMILY = 18'h3FF0F;

  // status bit positions
  localparam int unsigned ST_ENABLE  = 7;
  localparam int unsigned ST_ACTIVE  = 6;
  localparam int unsigned ST_SDV     = 4;
  localparam int unsigned ST_STEP    = 3;
  localparam int unsigned ST_RELEASE = 1;

  // page register fields
  localparam int unsigned PG_ENABLE = 7;
  localparam int unsigned PG_IDX_HI = 3;

  // reset values
  localparam logic [7:0] FLAGS_RST_SPECIAL = 8'hD8;
  localparam logic [7:0] FLAGS_RST_OTHER   = 8'h00;
  localparam logic [7:0] PAGE_RST          = 8'h00;
  localparam logic [7:0] ZERO_BYTE         = 8'h00;

  // arbitrary neutral family code
  localparam logic [7:0] FAMILY_IDENTIFIER_DEFAULT = 8'h5A;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        fw_src;
    logic [17:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic       page_en;
    logic [3:0] page_idx;
    logic       global_en;
  } page_sel_t;

endpackage : debug_regs_pkg

//--- tb/debug_host.sv
`timescale 1ns/10ps
`default_nettype none
module debug_host (
  input  wire logic                         i_core_clk,
  output var debug_regs_pkg::reg_req_t      o_req
);
  initial o_req = '0;
  // one request, held until the edge that takes it, then released
  task automatic xfer(input logic w, input logic fw, input logic [17:0] a,
                      input logic [7:0] d);
    @(posedge i_core_clk);
    o_req <= '{rd: ~w, wr: w, fw_src: fw, addr: a, wdata: d};
    @(posedge i_core_clk);
    o_req <= '0;
  endtask
endmodule // debug_host
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [17:0] A_ST = debug_regs_pkg::ADDR_STATUS;
  localparam logic [17:0] A_FL = debug_regs_pkg::ADDR_FLAGS;
  localparam logic [17:0] A_PG = debug_regs_pkg::ADDR_PAGE;
  localparam logic [17:0] A_ID = debug_regs_pkg::ADDR_FAMILY;
  logic i_core_clk, i_rst, sp, sec, eok, o_rvalid, o_debug_active, o_debug_enable;
  logic o_secure, o_secure_table, gq, rc;
  logic [6:0] ev;
  logic [7:0] condition_code_register, o_rdata, o_restore_ccr, v, p;
  logic [31:0] lf;
  int mismatches, cmp_count;
  debug_regs_pkg::reg_req_t req;
  debug_regs_pkg::page_sel_t o_page;
  debug_host host (.i_core_clk, .o_req(req));
  background_debug_registers dut (
    .i_core_clk, .i_rst, .i_special_mode(sp), .i_flash_secured(sec), .i_req(req),
    .i_global_req(gq), .i_reg_cmd(rc), .i_cmd_received(ev[0]), .i_data_done(ev[1]),
    .i_step_cmd(ev[2]), .i_resume_cmd(ev[3]), .i_enter_req(ev[4]), .i_exit_store(ev[5]),
    .i_erase_done(ev[6]), .i_erase_ok(eok), .i_cpu_ccr(condition_code_register), .o_rdata, .o_rvalid,
    .o_debug_active, .o_debug_enable, .o_secure, .o_secure_table, .o_restore_ccr, .o_page
  );
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected status byte: enable, active, data valid, single step
  function automatic logic [7:0] st(input logic e, a, s, t);
    return {e, a, 1'b0, s, t, 3'b000};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    host.xfer(1'b0, 1'b0, a, 8'h00);
    #1 chk({7'h00, o_rvalid}, 8'h01);
    chk(o_rdata, e);
  endtask
  task automatic pulse(input int k);
    @(posedge i_core_clk) ev <= 7'h01 << k;
    @(posedge i_core_clk) ev <= 7'h00;
    #1;
  endtask
  task automatic reset(input logic s, input logic c);
    @(posedge i_core_clk) begin
      i_rst <= 1'b1;
      sp <= s;
      sec <= c;
    end
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1ms mismatches++;
    give_verdict();
  end
  initial begin
    {i_rst, sp, sec, eok, ev, condition_code_register, gq, rc} = '0;
    i_rst = 1'b1;
    lf = 32'h3D1C135B;
    mismatches = 0;
    cmp_count = 0;
    reset(1'b1, 1'b0);
    chk({7'h00, o_secure}, 8'h00);
    chk({6'h00, o_debug_enable, o_debug_active}, 8'h03);
    rd(A_FL, 8'hD8);
    rd(A_ID, debug_regs_pkg::FAMILY_IDENTIFIER_DEFAULT);
    rd(A_ST, st(1, 1, 0, 0));
    pulse(1); rd(A_ST, st(1, 1, 1, 0));
    pulse(0); rd(A_ST, st(1, 1, 0, 0));
    pulse(2); pulse(0); rd(A_ST, st(1, 1, 0, 1));
    pulse(3); rd(A_ST, st(1, 1, 0, 0));
    repeat (8) begin
      lf = nx(lf);
      v = lf[7:0];
      p = lf[15:8];
      @(posedge i_core_clk) {gq, rc} <= lf[17:16];
      host.xfer(1'b1, 1'b0, A_FL, v);
      rd(A_FL, v);
      chk(o_restore_ccr, v);
      host.xfer(1'b1, 1'b0, A_PG, p);
      rd(A_PG, p & 8'h8F);
      chk({2'b00, o_page}, {2'b00, p[7], p[3:0], (rc ? 1'b0 : gq)});
    end
    @(posedge i_core_clk) {gq, rc} <= 2'b10;
    #1 chk({7'h00, o_page.global_en}, 8'h01);
    @(posedge i_core_clk) {gq, rc} <= 2'b11;
    #1 chk({7'h00, o_page.global_en}, 8'h00);
    pulse(1); pulse(5); rd(A_ST, st(1, 0, 0, 0));
    chk({7'h00, o_debug_active}, 8'h00);
    rd(A_ID, 8'h00);
    @(posedge i_core_clk) condition_code_register <= lf[23:16];
    pulse(4); rd(A_FL, lf[23:16]);
    rd(A_ST, st(1, 1, 0, 0));
    reset(1'b0, 1'b0);
    rd(A_FL, 8'h00);
    pulse(4); rd(A_ST, 8'h00);
    reset(1'b0, 1'b1);
    host.xfer(1'b1, 1'b0, A_FL, 8'hA5);
    rd(A_FL, 8'h00);
    chk(o_restore_ccr, 8'h00);
    host.xfer(1'b1, 1'b1, A_ST, 8'h02);
    #1 chk({7'h00, o_secure}, 8'h01);
    for (int ok = 1; ok >= 0; ok--) begin
      reset(1'b1, 1'b1);
      chk({6'h00, o_secure, o_secure_table}, 8'h03);
      host.xfer(1'b1, 1'b0, A_ST, 8'h02);
      #1 chk({7'h00, o_secure}, 8'h01);
      @(posedge i_core_clk) eok <= ok[0];
      pulse(6);
      chk({6'h00, o_secure, o_secure_table}, {6'h00, ~ok[0], ~ok[0]});
      host.xfer(1'b1, 1'b1, A_ST, 8'h02);
      #1 chk({7'h00, o_secure}, 8'h00);
    end
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
